// [core/gdic_consts.svh]
// Timing constants and functional notes for the gate drive input conditioning block.
// Functional notes
// - Every high-side, low-side, auxiliary and enable command passes through its own glitch filter before use.
// - A level shorter than the filter minimum time never changes the filtered output, so a rejected pulse has zero width.
// - While the filtered signal rests low, positive spikes shorter than the filter minimum time are suppressed.
// - While the filtered signal rests high, negative spikes shorter than the filter minimum time are suppressed.
// - An accepted pulse of either polarity leaves the filter with about the width it entered with.
// - Each high-side channel has a bootstrap switch that is on while its low-side output is high and off otherwise.
// - A channel's bootstrap switch is forced off while its floating supply is above about 110% of the logic supply.
// - A switch-node swing below -20 V lasting over 100 ns holds all high-side outputs off for 4.5 us.
`ifndef GDIC_CONSTS_SVH
`define GDIC_CONSTS_SVH

`define GDIC_CLK_PERIOD_NS 100
`define GDIC_FILTER_MIN_TIME_NS 200
`define GDIC_FILTER_CYCLES ((`GDIC_FILTER_MIN_TIME_NS + `GDIC_CLK_PERIOD_NS - 1) / `GDIC_CLK_PERIOD_NS)
`define GDIC_FILTER_CNT_W 4
`define GDIC_HS_MIN_PULSE_NS 500
`define GDIC_NEG_QUAL_NS 100
`define GDIC_NEG_QUAL_CYCLES ((`GDIC_NEG_QUAL_NS + `GDIC_CLK_PERIOD_NS - 1) / `GDIC_CLK_PERIOD_NS)
`define GDIC_HOLDOFF_NS 4500
`define GDIC_HOLDOFF_CYCLES (`GDIC_HOLDOFF_NS / `GDIC_CLK_PERIOD_NS)
`define GDIC_HOLD_CNT_W 8
`define GDIC_NUM_PHASES 3
`define GDIC_NUM_INPUTS 8

`endif

// [core/gdic_pkg.sv]
// Types shared by the gate drive input conditioning block.
`default_nettype none
package gdic_pkg;
    typedef struct packed {
        logic enable;
        logic aux_switch_cmd;
        logic [2:0] low_side_cmd;
        logic [2:0] high_side_cmd;
    } gdic_cmd_type;

    typedef struct packed {
        logic aux_switch_drive;
        logic [2:0] bottom_gate_drive;
        logic [2:0] top_gate_drive;
    } gdic_drive_type;
endpackage : gdic_pkg
`default_nettype wire

// [core/gdic_filter.sv]
// Symmetric glitch filter for one command input.
`include "gdic_consts.svh"
`default_nettype none
module gdic_filter
#(
    parameter int unsigned CYCLES = `GDIC_FILTER_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic raw,
    output logic filt_q
);
    localparam logic [`GDIC_FILTER_CNT_W-1:0] LAST = `GDIC_FILTER_CNT_W'(CYCLES - 1);

    logic [`GDIC_FILTER_CNT_W-1:0] cnt_q;

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            cnt_q <= '0;
            filt_q <= 1'b0;
        end
        else if (raw == filt_q)
        begin
            cnt_q <= '0;
        end
        else if (cnt_q == LAST)
        begin
            cnt_q <= '0;
            filt_q <= raw;
        end
        else
        begin
            cnt_q <= cnt_q + `GDIC_FILTER_CNT_W'(1);
        end
    end

    spike_low_a: assert property (@(posedge sys_clk) disable iff (reset)
        (!filt_q && raw && cnt_q == '0) ##1 !raw |=> !filt_q)
        else $error("Short positive spike reached the filtered output.");

    spike_high_a: assert property (@(posedge sys_clk) disable iff (reset)
        (filt_q && !raw && cnt_q == '0) ##1 raw |=> filt_q)
        else $error("Short negative spike reached the filtered output.");

    change_needs_persist_a: assert property (@(posedge sys_clk) disable iff (reset)
        $changed(filt_q) |-> $past(raw, 1) == filt_q && $past(raw, 2) == filt_q)
        else $error("Filtered output changed before the input persisted.");

    flip_at_count_a: assert property (@(posedge sys_clk) disable iff (reset)
        (raw != filt_q && cnt_q == LAST) |=> (filt_q == $past(raw) && cnt_q == '0))
        else $error("Filter did not follow a persisted level on time.");

endmodule : gdic_filter
`default_nettype wire

// [core/gdic_top.sv]
// Input conditioning, bootstrap switch control and negative transient hold-off of the gate driver.
`include "gdic_consts.svh"
`default_nettype none
module gdic_top
    import gdic_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire gdic_cmd_type cmd,
    input wire logic [2:0] supply_over_thresh,
    input wire logic neg_transient,
    output gdic_drive_type drive_q,
    output logic [2:0] boot_switch_q,
    output logic holdoff_q
);
    localparam logic [`GDIC_HOLD_CNT_W-1:0] HOLD_LOAD = `GDIC_HOLD_CNT_W'(`GDIC_HOLDOFF_CYCLES);
    localparam logic [1:0] NEG_QUAL = 2'(`GDIC_NEG_QUAL_CYCLES);
    localparam logic [`GDIC_HOLD_CNT_W-1:0] QUIET_DONE = `GDIC_HOLD_CNT_W'(`GDIC_HOLDOFF_CYCLES + 1);

    typedef enum logic [1:0] {
        GDIC_IDLE,
        GDIC_QUALIFY,
        GDIC_HOLD
    } gdic_hold_state_type;

    gdic_cmd_type cmd_f;
    gdic_drive_type drive_d;
    gdic_hold_state_type hold_state_q;
    logic [`GDIC_HOLD_CNT_W-1:0] hold_cnt_q;
    logic [1:0] neg_cnt_q;
    logic neg_trigger;
    logic hold_active;
    logic [2:0] boot_d;
    logic [`GDIC_HOLD_CNT_W-1:0] quiet_cnt_q;

    genvar gi;
    generate
        for (gi = 0; gi < `GDIC_NUM_INPUTS; gi++)
        begin : g_filter
            gdic_filter #(
                .CYCLES(`GDIC_FILTER_CYCLES)
            ) u_filter (
                .sys_clk(sys_clk),
                .reset(reset),
                .raw(cmd[gi]),
                .filt_q(cmd_f[gi])
            );
        end
    endgenerate

    // The transient is qualified only once it has outlasted the minimum duration.
    assign neg_trigger = neg_transient && (neg_cnt_q >= NEG_QUAL);
    assign hold_active = neg_trigger || (hold_state_q == GDIC_HOLD);

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            neg_cnt_q <= '0;
        end
        else if (!neg_transient)
        begin
            neg_cnt_q <= '0;
        end
        else if (neg_cnt_q < NEG_QUAL)
        begin
            neg_cnt_q <= neg_cnt_q + 2'(1);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            hold_state_q <= GDIC_IDLE;
            hold_cnt_q <= '0;
        end
        else if (neg_trigger)
        begin
            hold_state_q <= GDIC_HOLD;
            hold_cnt_q <= HOLD_LOAD;
        end
        else
        begin
            unique case (hold_state_q)
                GDIC_IDLE:
                begin
                    if (neg_transient)
                    begin
                        hold_state_q <= GDIC_QUALIFY;
                    end
                end
                GDIC_QUALIFY:
                begin
                    if (!neg_transient)
                    begin
                        hold_state_q <= GDIC_IDLE;
                    end
                end
                GDIC_HOLD:
                begin
                    if (hold_cnt_q == `GDIC_HOLD_CNT_W'(1))
                    begin
                        hold_state_q <= GDIC_IDLE;
                    end
                    hold_cnt_q <= hold_cnt_q - `GDIC_HOLD_CNT_W'(1);
                end
                default:
                begin
                    hold_state_q <= GDIC_IDLE;
                    hold_cnt_q <= '0;
                end
            endcase
        end
    end

    // Counts quiet cycles since the last trigger so the hold-off length can be checked without a long repetition.
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            quiet_cnt_q <= '0;
        end
        else if (neg_trigger)
        begin
            quiet_cnt_q <= `GDIC_HOLD_CNT_W'(1);
        end
        else if (neg_transient || quiet_cnt_q == '0 || quiet_cnt_q == QUIET_DONE)
        begin
            quiet_cnt_q <= '0;
        end
        else
        begin
            quiet_cnt_q <= quiet_cnt_q + `GDIC_HOLD_CNT_W'(1);
        end
    end

    // Disabled commands turn every gate, auxiliary and bootstrap switch output off; the hold-off only touches the high side.
    always_comb
    begin
        drive_d.top_gate_drive = cmd_f.high_side_cmd & {3{cmd_f.enable && !hold_active}};
        drive_d.bottom_gate_drive = cmd_f.low_side_cmd & {3{cmd_f.enable}};
        drive_d.aux_switch_drive = cmd_f.aux_switch_cmd && cmd_f.enable;
    end

    assign boot_d = drive_d.bottom_gate_drive & ~supply_over_thresh;

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            drive_q <= '0;
        end
        else
        begin
            drive_q <= drive_d;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            boot_switch_q <= '0;
        end
        else
        begin
            boot_switch_q <= boot_d;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            holdoff_q <= 1'b0;
        end
        else
        begin
            holdoff_q <= hold_active;
        end
    end

    enable_gates_all_a: assert property (@(posedge sys_clk) disable iff (reset)
        !cmd_f.enable |=> drive_q == '0)
        else $error("Outputs active while the filtered enable is low.");

    boot_follows_low_a: assert property (@(posedge sys_clk) disable iff (reset)
        ##1 boot_switch_q == (drive_q.bottom_gate_drive & ~$past(supply_over_thresh)))
        else $error("Bootstrap switch does not follow the low-side output.");

    boot_over_off_a: assert property (@(posedge sys_clk) disable iff (reset)
        supply_over_thresh[0] |=> !boot_switch_q[0])
        else $error("Bootstrap switch on while the floating supply is over threshold.");

    holdoff_top_off_a: assert property (@(posedge sys_clk) disable iff (reset)
        neg_trigger |=> (drive_q.top_gate_drive == '0) [*8])
        else $error("High-side output on during the transient hold-off.");

    holdoff_length_a: assert property (@(posedge sys_clk) disable iff (reset)
        quiet_cnt_q == QUIET_DONE |-> hold_state_q == GDIC_IDLE && $past(hold_state_q) == GDIC_HOLD)
        else $error("Hold-off did not last the programmed count.");

    short_transient_a: assert property (@(posedge sys_clk) disable iff (reset)
        (!neg_transient ##1 neg_transient ##1 !neg_transient) |-> !neg_trigger && hold_state_q != GDIC_HOLD)
        else $error("A one-cycle switch-node transient started the hold-off.");

    held_outputs_a: assert property (@(posedge sys_clk) disable iff (reset)
        hold_active |=> !holdoff_q || drive_q.top_gate_drive == '0)
        else $error("Hold-off flag and high-side outputs disagree.");

    low_side_free_a: assert property (@(posedge sys_clk) disable iff (reset)
        (hold_active && cmd_f.enable) |=> drive_q.bottom_gate_drive == $past(cmd_f.low_side_cmd))
        else $error("Hold-off wrongly touched the low-side outputs.");

endmodule : gdic_top
`default_nettype wire

// [verif/gdic_ctrl_model.sv]
// Controller model that drives the raw command inputs of the conditioning block.
`default_nettype none
module gdic_ctrl_model
    import gdic_pkg::*;
(
    input wire logic sys_clk,
    input wire logic glitch,
    input wire logic [31:0] rnd,
    output var gdic_cmd_type cmd
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] lvl_q = 8'h00;
    logic [7:0] spike_q = 8'h00;
    logic [2:0] hold_q [8] = '{default: 3'h0};
    initial cmd = gdic_cmd_type'(8'h00);
    always @(negedge sys_clk)
    begin
        // minimum pulse width: a settled level is kept for five cycles at least.
        for (int i = 0; i < 8; i++)
        begin
            if (hold_q[i] == 3'h0 && rnd[i])
            begin
                lvl_q[i] = ~lvl_q[i];
                hold_q[i] = 3'h4;
            end
            else if (hold_q[i] != 3'h0)
                hold_q[i] = hold_q[i] - 3'h1;
        end
        // Noise spikes last one cycle and never come back to back on one line.
        spike_q = glitch ? (rnd[15:8] & ~spike_q) : 8'h00;
        cmd = gdic_cmd_type'(lvl_q ^ spike_q);
    end
endmodule : gdic_ctrl_model
`default_nettype wire

// [verif/gdic_top_tb.sv]
// Self-checking testbench of the gate drive input conditioning block.
`include "gdic_consts.svh"
`default_nettype none
module gdic_top_tb
    import gdic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic glitch = 1'b0;
    logic neg_transient = 1'b0;
    logic [2:0] supply_over_thresh = 3'h0;
    logic [31:0] rnd = 32'h7122FC72;
    gdic_cmd_type cmd;
    gdic_drive_type drive_q;
    logic [2:0] boot_switch_q;
    logic holdoff_q;
    int failures = 0;
    int tests_run = 0;
    logic [10:0] exp_q [$];
    logic [7:0] mf;
    int fc [8];
    int hc;
    logic nq;
    logic tq;
    logic hold;
    gdic_drive_type ed;

    always #50 sys_clk = ~sys_clk;

    gdic_ctrl_model gdic_ctrl_model_i (.sys_clk(sys_clk), .glitch(glitch), .rnd(rnd), .cmd(cmd));
    gdic_top gdic_top_i (.sys_clk(sys_clk), .reset(reset), .cmd(cmd), .supply_over_thresh(supply_over_thresh),
        .neg_transient(neg_transient), .drive_q(drive_q), .boot_switch_q(boot_switch_q), .holdoff_q(holdoff_q));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h00000000);
    endfunction : lfsr

    task automatic check(input string what, input logic [6:0] seen, input logic [6:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic summarize();
        $display("Comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize

    always @(posedge sys_clk) rnd <= lfsr(rnd);
    always @(negedge sys_clk) supply_over_thresh = rnd[18:16] & rnd[21:19];

    // Reference of the block: notes one expected output word at every edge.
    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            mf = 8'h00;
            fc = '{default: 0};
            nq = 1'b0;
            tq = 1'b0;
            hc = 0;
            ed = '0;
            exp_q.push_back(11'h000);
        end
        else
        begin
            // hold-off: two high samples trigger, then a fixed count of cycles.
            tq = neg_transient && nq;
            nq = neg_transient;
            hold = tq || (hc != 0);
            if (tq)
                hc = `GDIC_HOLDOFF_CYCLES;
            else if (hc != 0)
                hc--;
            ed.top_gate_drive = mf[7] ? (mf[2:0] & {3{~hold}}) : 3'h0;
            ed.bottom_gate_drive = mf[7] ? mf[5:3] : 3'h0;
            ed.aux_switch_drive = mf[7] & mf[6];
            // filter: a new level is followed after the minimum count of samples.
            for (int i = 0; i < 8; i++)
            begin
                if (cmd[i] === mf[i])
                    fc[i] = 0;
                else if (fc[i] + 1 >= `GDIC_FILTER_CYCLES)
                begin
                    mf[i] = cmd[i];
                    fc[i] = 0;
                end
                else
                    fc[i]++;
            end
            exp_q.push_back({hold, ed.bottom_gate_drive & ~supply_over_thresh, ed});
        end
    end

    // Watcher: every edge yields a result, compared with the oldest note.
    always @(negedge sys_clk)
    begin
        logic [10:0] e;
        if (exp_q.size() > 0)
        begin
            e = exp_q.pop_front();
            check("drive", drive_q, e[6:0]);
            check("boot switch", {4'h0, boot_switch_q}, {4'h0, e[9:7]});
            check("holdoff", {6'h00, holdoff_q}, {6'h00, e[10]});
        end
    end

    task automatic neg_pulse(input int len, input int gap);
        neg_transient = 1'b1;
        repeat (len) @(negedge sys_clk);
        neg_transient = 1'b0;
        repeat (gap) @(negedge sys_clk);
    endtask : neg_pulse

    initial
    begin
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk);
        reset = 1'b0;
        repeat (400) @(negedge sys_clk);
        neg_pulse(1, 20);
        neg_pulse(2, 70);
        glitch = 1'b1;
        repeat (400) @(negedge sys_clk);
        neg_pulse(3, 20);
        neg_pulse(2, 70);
        reset = 1'b1;
        repeat (2) @(negedge sys_clk);
        reset = 1'b0;
        repeat (300) @(negedge sys_clk);
        glitch = 1'b0;
        repeat (200) @(negedge sys_clk);
        summarize();
    end
endmodule : gdic_top_tb
`default_nettype wire
